// file: core/object_dictionary_access.sv
// Object dictionary front end with APB register access
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module object_dictionary_access
  import od_pkg::*;
#(
  parameter int GROUPS    = 16,
  parameter int GROUP_LEN = 16
)(
  input  wire logic        pclk,        // APB clock, 50 MHz
  input  wire logic        presetn,     // Asynchronous reset, active low
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB access phase
  input  wire logic        pwrite,      // APB direction
  input  wire logic [7:0]  paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic [31:0]      prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  output logic             irq,         // Level interrupt
  output logic [15:0]      warning_code, // Restart warning code or zero
  output logic [31:0]      op_value,    // Value of the parameter that last took effect
  output logic [15:0]      op_index,    // Index of op_value
  output logic [7:0]       op_subindex  // Subindex of op_value
);
  import od_pkg::*;

  // Entry number = group * GROUP_LEN + position within the group
  localparam int ENTRIES = GROUPS * GROUP_LEN;
  localparam int AW      = $clog2(ENTRIES);

  typedef struct packed {
    logic [15:0]     req_index;
    logic [7:0]      req_sub;
    logic [4:0]      req_ctrl;
    logic [31:0]     req_data;
    logic [31:0]     resp_code;
    logic [31:0]     resp_data;
    logic [2:0]      resp_area;
    logic [ST_BITS-1:0] status;
    logic [ST_BITS-1:0] mask;
    logic            operational;
    logic            pend_valid;
    logic [AW-1:0]   pend_addr;
    logic [31:0]     pend_data;
    logic [31:0]     op_value;
    logic [15:0]     op_index;
    logic [7:0]      op_sub;
    logic [31:0]     prdata;
    logic [ENTRIES-1:0] written;  // Entry stored at least once since reset
    logic            ready;
  } state_type;

  // Registered state of the block apart from stored_mem; d is its next value
  state_type q;
  state_type d;

  // Values kept apart from the struct: array, written by one always_ff.
  // The effective copy is not kept per entry: op_value carries the value
  // that last took effect, which is all the operating side is shown.
  logic [31:0] stored_mem [ENTRIES];
  logic        mem_we;
  logic [AW-1:0] mem_addr;
  logic [31:0] mem_data;
  logic        act_we;
  logic [AW-1:0] act_addr;
  logic [31:0] act_data;

  logic        apb_wr;
  logic        apb_rd;
  logic [2:0]  area;
  logic        mapped;
  logic [AW-1:0] addr;
  attr_type    attr;
  logic [31:0] ev;
  logic [31:0] rd_word;

  // A write lands only on the edge that completes the transfer, so one
  // control write starts exactly one request despite the wait state.
  // Read data is captured on the first access edge and stands while
  // pready is high, then drops back to zero.
  assign apb_wr = psel && penable && pwrite && q.ready;
  assign apb_rd = psel && penable && !pwrite && !q.ready;

  // Range flags for the index decode
  logic in_static;
  logic in_complex;
  logic in_typedef;
  logic in_comm;
  logic in_vendor;
  logic in_profile;
  assign in_static  = q.req_index >= STATIC_TYPE_LO && q.req_index <= STATIC_TYPE_HI;
  assign in_complex = q.req_index >= COMPLEX_TYPE_LO && q.req_index <= COMPLEX_TYPE_HI;
  assign in_typedef = q.req_index > COMPLEX_TYPE_HI && q.req_index <= PROFILE_TYPE_HI;
  assign in_comm    = q.req_index >= COMM_LO && q.req_index <= COMM_HI;
  assign in_vendor  = q.req_index >= VENDOR_LO && q.req_index <= VENDOR_HI;
  assign in_profile = q.req_index >= PROFILE_LO && q.req_index <= PROFILE_HI;

  // Area decode of the requested index
  // Index zero, 00A0h-0FFFh and A000h-FFFFh fall through to no area;
  // only the vendor area holds parameters, every other area aborts.
  always_comb
  begin
    if (in_static)
      area = AREA_STATIC;
    else if (in_complex)
      area = AREA_COMPLEX;
    else if (in_typedef)
      area = AREA_TYPEDEF;
    else if (in_comm)
      area = AREA_COMM;
    else if (in_vendor)
      area = AREA_VENDOR;
    else if (in_profile)
      area = AREA_PROFILE;
    else
      area = AREA_NONE;
  end

  // Group G at 2000h+G, position p at subindex p+1; subindex zero unmapped
  always_comb
  begin
    logic [15:0] grp;
    logic [7:0]  pos;
    logic        grp_ok;
    logic        sub_ok;
    grp    = q.req_index - PARAM_BASE;
    pos    = q.req_sub - 8'h01;
    grp_ok = grp < 16'(GROUPS);
    // Subindex zero wraps pos to FFh, so it is refused explicitly
    sub_ok = (q.req_sub != 8'h00) && (pos < 8'(GROUP_LEN));
    mapped = (area == AREA_VENDOR) && grp_ok && sub_ok;
    addr   = AW'(grp * 16'(GROUP_LEN) + 16'(pos));
  end

  // Attributes derived per entry; a compact fixed pattern stands in for a ROM.
  // With e the entry number:
  //   e[1:0]  data type: int32, uint16, uint8, int16
  //   e[2]    receive mappable, else e[3] transmit mappable, else not mappable
  //   e[0]    editable at stop only, else while running
  //   e[3:2]  all ones: next power-on; else e[1] at stop; else at once
  //   e[2]    concerns all modes, else no mode
  // A real dictionary swaps this for a table; the checks below stay the same.
  always_comb
  begin
    attr.structure = (GROUP_LEN > 1) ? STRUCT_ARR : STRUCT_VAR;
    case (addr[1:0])
      2'h0: attr.dtype = DT_INT32;
      2'h1: attr.dtype = DT_UINT16;
      2'h2: attr.dtype = DT_UINT8;
      default: attr.dtype = DT_INT16;
    endcase
    attr.access  = ACC_RW;
    attr.mapping = addr[2] ? MAP_RPDO : (addr[3] ? MAP_TPDO : MAP_NO);
    attr.setting = addr[0] ? SET_STOP : SET_RUN;
    attr.effect  = addr[3:2] == 2'h3 ? EFF_POWER : (addr[1] ? EFF_STOP : EFF_ONCE);
    attr.modes   = addr[2] ? MODE_ALL : MODE_NONE;
    attr.lo      = 32'h0000_0000;
    attr.hi      = (attr.dtype == DT_UINT8) ? 32'h0000_00FF : 32'h0000_FFFF;
  end

  always_comb
  begin
    d      = q;
    mem_we = 1'b0;
    act_we = 1'b0;
    mem_addr = addr;
    mem_data = q.req_data;
    act_addr = addr;
    act_data = q.req_data;
    ev     = 32'h0;

    // One wait state on every transfer: ready follows the first access cycle
    d.ready = psel && penable && !q.ready;

    // Operational state left: apply a pending stop-effect value
    // A request taking effect in the same cycle does not reach op_value: act_addr and act_data keep the pending value
    if (q.pend_valid && !q.operational)
    begin
      act_we       = 1'b1;
      act_addr     = q.pend_addr;
      act_data     = q.pend_data;
      d.pend_valid = 1'b0;
      ev[ST_APPLIED] = 1'b1;
    end

    // A request runs in the cycle after GO is written and GO clears itself,
    // so one control write gives one answer. Checks run in priority order:
    // object exists, mapping check, read, access, setting, range.
    if (q.req_ctrl[CTRL_GO])
    begin
      d.req_ctrl[CTRL_GO] = 1'b0;
      d.resp_area = area;
      d.resp_code = ABORT_NONE;
      d.resp_data = 32'h0;
      ev[ST_DONE] = 1'b1;
      if (!mapped)
        d.resp_code = ABORT_NO_OBJ;
      else if (q.req_ctrl[CTRL_MAPCK])
      begin
        // Mapping check only: answers with a code, stores nothing
        if (attr.mapping == MAP_NO)
          d.resp_code = ABORT_NOMAP;
        else if ((attr.mapping == MAP_TPDO) != q.req_ctrl[CTRL_TXMAP])
          d.resp_code = ABORT_NOMAP;
      end
      else if (!q.req_ctrl[CTRL_WRITE])
      begin
        if (attr.access == ACC_WO)
          d.resp_code = ABORT_WO;
        // An entry never written reads as zero, not as unset memory
        else if (q.written[addr])
          d.resp_data = stored_mem[addr];
      end
      else if (attr.access == ACC_RO || attr.access == ACC_CONST)
        d.resp_code = ABORT_RO;
      else if (attr.setting == SET_STOP && q.operational)
        d.resp_code = ABORT_STATE;
      // Process-data writes skip the limits; service-data writes are checked
      else if (!q.req_ctrl[CTRL_PDO]
               && (q.req_data < attr.lo || q.req_data > attr.hi))
        d.resp_code = ABORT_RANGE;
      else
      begin
        // Setting-running objects reach here in any state
        mem_we = 1'b1;
        d.written[addr] = 1'b1;
        if (attr.effect == EFF_ONCE)
          act_we = 1'b1;
        else if (attr.effect == EFF_STOP)
        begin
          if (q.operational)
          begin
            // Single pending slot: a newer stop-effect write replaces it
            d.pend_valid = 1'b1;
            d.pend_addr  = addr;
            d.pend_data  = q.req_data;
          end
          else
            act_we = 1'b1;
        end
        // A first write after reset counts as a change: the value before it
        // is unknown. The stored copy updates now, the effect waits for the
        // next power-up, so op_value is left alone.
        else if (!q.written[addr] || q.req_data != stored_mem[addr])
          ev[ST_RESTART] = 1'b1;
      end
      if (d.resp_code != ABORT_NONE)
        ev[ST_ABORT] = 1'b1;
    end

    // op_index and op_subindex are rebuilt from the entry number, so once set
    // they name a mapped parameter; reset leaves them zero
    if (act_we)
    begin
      d.op_value = act_data;
      d.op_index = PARAM_BASE + 16'(act_addr / AW'(GROUP_LEN));
      d.op_sub   = 8'(act_addr % AW'(GROUP_LEN)) + 8'h01;
    end

    // APB writes; hardware events win over write-one-to-clear
    // Unused or misaligned addresses match no register and are dropped
    d.status = q.status | ev[ST_BITS-1:0];
    if (apb_wr)
    begin
      if (paddr == REG_REQ_INDEX)
      begin
        d.req_index = pwdata[15:0];
        d.req_sub   = pwdata[23:16];
      end
      else if (paddr == REG_REQ_CTRL)
        d.req_ctrl = pwdata[4:0];
      else if (paddr == REG_REQ_DATA)
        d.req_data = pwdata;
      else if (paddr == REG_STATUS)
        d.status = (q.status & ~pwdata[ST_BITS-1:0]) | ev[ST_BITS-1:0];
      else if (paddr == REG_MASK)
        d.mask = pwdata[ST_BITS-1:0];
      else if (paddr == REG_NETSTATE)
        d.operational = pwdata[0];
    end

    d.prdata = apb_rd ? rd_word : 32'h0;
  end

  // Register read mux; addresses with no register read as zero
  always_comb
  begin
    rd_word = 32'h0;
    if (paddr == REG_REQ_INDEX)
      rd_word = {8'h00, q.req_sub, q.req_index};
    else if (paddr == REG_REQ_CTRL)
      rd_word = {27'h0, q.req_ctrl};
    else if (paddr == REG_REQ_DATA)
      rd_word = q.req_data;
    else if (paddr == REG_RESP)
      rd_word = q.resp_code;
    else if (paddr == REG_RESP_DATA)
      rd_word = q.resp_data;
    else if (paddr == REG_ATTR)
      rd_word = {attr.modes, 5'h00, q.resp_area, attr.effect, attr.setting,
                 attr.mapping, attr.access, attr.dtype, attr.structure, 1'b0};
    else if (paddr == REG_STATUS)
      rd_word = {28'h0, q.status};
    else if (paddr == REG_MASK)
      rd_word = {28'h0, q.mask};
    else if (paddr == REG_NETSTATE)
      rd_word = {31'h0, q.operational};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  // Stored value is what software reads; no reset, the written bits cover it
  always_ff @(posedge pclk)
  begin
    if (mem_we)
      stored_mem[mem_addr] <= mem_data;
  end

  logic addr_ok;
  assign addr_ok = paddr[1:0] == 2'h0 && paddr <= REG_NETSTATE;

  assign pready       = q.ready;
  assign pslverr      = q.ready && !addr_ok;
  assign prdata       = q.prdata;
  assign irq          = |(q.status & q.mask);
  assign warning_code = q.status[ST_RESTART] ? RESTART_REQUIRED_WARNING : 16'h0000;
  assign op_value     = q.op_value;
  assign op_index     = q.op_index;
  assign op_subindex  = q.op_sub;
endmodule

// file: core/od_pkg.sv
// Constants and types shared by the object dictionary access block
package od_pkg;
  // Index area bounds
  localparam logic [15:0] STATIC_TYPE_LO  = 16'h0001;
  localparam logic [15:0] STATIC_TYPE_HI  = 16'h001F;
  localparam logic [15:0] COMPLEX_TYPE_LO = 16'h0020;
  localparam logic [15:0] COMPLEX_TYPE_HI = 16'h003F;
  localparam logic [15:0] PROFILE_TYPE_HI = 16'h009F;
  localparam logic [15:0] COMM_LO         = 16'h1000;
  localparam logic [15:0] COMM_HI         = 16'h1FFF;
  localparam logic [15:0] VENDOR_LO       = 16'h2000;
  localparam logic [15:0] VENDOR_HI       = 16'h5FFF;
  localparam logic [15:0] PROFILE_LO      = 16'h6000;
  localparam logic [15:0] PROFILE_HI      = 16'h9FFF;
  localparam logic [15:0] PARAM_BASE      = 16'h2000;

  // Area classification codes
  localparam logic [2:0] AREA_NONE    = 3'h0;
  localparam logic [2:0] AREA_STATIC  = 3'h1;
  localparam logic [2:0] AREA_COMPLEX = 3'h2;
  localparam logic [2:0] AREA_TYPEDEF = 3'h3;
  localparam logic [2:0] AREA_COMM    = 3'h4;
  localparam logic [2:0] AREA_VENDOR  = 3'h5;
  localparam logic [2:0] AREA_PROFILE = 3'h6;

  // Object structure codes
  localparam logic [3:0] STRUCT_VAR = 4'h7;
  localparam logic [3:0] STRUCT_ARR = 4'h8;
  localparam logic [3:0] STRUCT_REC = 4'h9;

  // Data type codes
  localparam logic [3:0] DT_INT8   = 4'h2;
  localparam logic [3:0] DT_INT16  = 4'h3;
  localparam logic [3:0] DT_INT32  = 4'h4;
  localparam logic [3:0] DT_UINT8  = 4'h5;
  localparam logic [3:0] DT_UINT16 = 4'h6;
  localparam logic [3:0] DT_UINT32 = 4'h7;
  localparam logic [3:0] DT_STRING = 4'h9;

  // Access, mapping, setting condition, effective time
  localparam logic [1:0] ACC_RW = 2'h0;
  localparam logic [1:0] ACC_WO = 2'h1;
  localparam logic [1:0] ACC_RO = 2'h2;
  localparam logic [1:0] ACC_CONST = 2'h3;
  localparam logic [1:0] MAP_NO   = 2'h0;
  localparam logic [1:0] MAP_RPDO = 2'h1;
  localparam logic [1:0] MAP_TPDO = 2'h2;
  localparam logic       SET_STOP = 1'b0;
  localparam logic       SET_RUN  = 1'b1;
  localparam logic [1:0] EFF_ONCE  = 2'h0;
  localparam logic [1:0] EFF_STOP  = 2'h1;
  localparam logic [1:0] EFF_POWER = 2'h2;

  // Related mode: bit 0 none/all flag layout, bits 7:1 listed profile modes
  localparam logic [7:0] MODE_NONE = 8'h00;
  localparam logic [7:0] MODE_ALL  = 8'h01;

  // Abort codes returned in the answer
  localparam logic [31:0] ABORT_NONE    = 32'h0000_0000;
  localparam logic [31:0] ABORT_NO_OBJ  = 32'h0602_0000;
  localparam logic [31:0] ABORT_RO      = 32'h0601_0002;
  localparam logic [31:0] ABORT_WO      = 32'h0601_0001;
  localparam logic [31:0] ABORT_STATE   = 32'h0800_0022;
  localparam logic [31:0] ABORT_RANGE   = 32'h0609_0030;
  localparam logic [31:0] ABORT_NOMAP   = 32'h0604_0041;

  localparam logic [15:0] RESTART_REQUIRED_WARNING = 16'h0941;

  // APB register byte offsets
  localparam logic [7:0] REG_REQ_INDEX = 8'h00;
  localparam logic [7:0] REG_REQ_CTRL  = 8'h04;
  localparam logic [7:0] REG_REQ_DATA  = 8'h08;
  localparam logic [7:0] REG_RESP      = 8'h0C;
  localparam logic [7:0] REG_RESP_DATA = 8'h10;
  localparam logic [7:0] REG_ATTR      = 8'h14;
  localparam logic [7:0] REG_STATUS    = 8'h18;
  localparam logic [7:0] REG_MASK      = 8'h1C;
  localparam logic [7:0] REG_NETSTATE  = 8'h20;

  // Control register fields
  localparam int CTRL_GO    = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_PDO   = 2;
  localparam int CTRL_TXMAP = 3;
  localparam int CTRL_MAPCK = 4;

  // Status bits
  localparam int ST_DONE    = 0;
  localparam int ST_ABORT   = 1;
  localparam int ST_RESTART = 2;
  localparam int ST_APPLIED = 3;
  localparam int ST_BITS    = 4;

  typedef struct packed {
    logic [3:0]  structure;
    logic [3:0]  dtype;
    logic [1:0]  access;
    logic [1:0]  mapping;
    logic        setting;
    logic [1:0]  effect;
    logic [7:0]  modes;
    logic [31:0] lo;
    logic [31:0] hi;
  } attr_type;
endpackage

// file: dv/od_checker_assertions.sv
// Port checker for the object dictionary access block
`timescale 1ns/100ps
module od_checker
  import od_pkg::*;
#(
  parameter int GROUPS    = 16,
  parameter int GROUP_LEN = 16
)(
  input wire logic        pclk,         // clock
  input wire logic        presetn,      // reset, active low
  input wire logic        psel,         // select
  input wire logic        penable,      // access phase
  input wire logic        pwrite,       // direction
  input wire logic [7:0]  paddr,        // address
  input wire logic [31:0] prdata,       // read data
  input wire logic        pready,       // ready
  input wire logic        pslverr,      // error
  input wire logic        irq,          // interrupt
  input wire logic [15:0] warning_code, // warning
  input wire logic [31:0] op_value,     // effective value
  input wire logic [15:0] op_index,     // its index
  input wire logic [7:0]  op_subindex   // its subindex
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc    = psel & penable;
  wire wr_hit = acc & pready & pwrite;
  wire bad    = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
  ready_one_a: assert property (pready |=> !pready) else $error("pready held too long");
  wait_state_a: assert property (psel && $rose(penable) |-> !pready ##1 (pready && penable))
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  bad_addr_a: assert property (acc && pready && bad |-> pslverr) else $error("bad address taken");
  good_addr_a: assert property (acc && pready && !bad |-> !pslverr) else $error("good address refused");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  warn_code_a: assert property (warning_code == 16'h0 || warning_code == RESTART_REQUIRED_WARNING)
    else $error("unexpected warning code");
  obj_index_a: assert property ($changed(op_index) |-> op_index >= PARAM_BASE
    && op_index < PARAM_BASE + GROUPS) else $error("op_index outside mapped groups");
  obj_sub_a: assert property ($changed(op_subindex) |-> op_subindex >= 8'h01
    && op_subindex <= GROUP_LEN) else $error("op_subindex outside group");
  effect_cause_a: assert property ($changed(op_value) |-> $past(wr_hit)
    || $past(wr_hit, 2) || $past(wr_hit, 3)) else $error("op_value changed without a write");
  irq_cause_a: assert property ($rose(irq) |-> $past(wr_hit) || $past(wr_hit, 2)
    || $past(wr_hit, 3)) else $error("irq rose without a write");
  cover property (pslverr);
  cover property ($changed(op_value));
  cover property (warning_code != 16'h0);
  cover property ($fell(irq));
endmodule

bind object_dictionary_access od_checker #(.GROUPS(GROUPS), .GROUP_LEN(GROUP_LEN)) od_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .warning_code(warning_code), .op_value(op_value), .op_index(op_index),
  .op_subindex(op_subindex));

// file: dv/net_master.sv
// Network master model issuing APB transfers
`timescale 1ns/100ps
module net_master (
  input  wire logic        pclk,    // clock
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic [7:0]       paddr,   // address
  output logic [31:0]      pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready   // ready
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // Held until pready is seen high; data inverted on release so stale bits never look valid
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask
endmodule

// file: dv/tb_object_dictionary_access.sv
// Self-checking bench for the object dictionary access block
`timescale 1ns/100ps
module tb_object_dictionary_access;
  import od_pkg::*;
  typedef struct {bit rd; logic err; logic [31:0] m; logic [31:0] d;} note_type;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, op_subindex;
  logic [31:0] pwdata, prdata, op_value, rq, rv;
  logic [15:0] warning_code, op_index;
  note_type    notes[$];
  note_type    nt;
  int          fail_count, cmp_count, cyc, seed;
  logic [15:0] bad_ix[6] = '{16'h0000, 16'h0001, 16'h00A0, 16'h1000, 16'hA000, 16'h6000};

  object_dictionary_access #(.GROUPS(16), .GROUP_LEN(16)) object_dictionary_access_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .warning_code(warning_code), .op_value(op_value), .op_index(op_index),
    .op_subindex(op_subindex));
  net_master net_master_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Oldest note belongs to the transfer that completes now
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      nt = notes.pop_front();
      chk("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
      if (nt.rd)
        chk("prdata", nt.d, prdata & nt.m);
    end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    notes.push_back('{1'b0, err, 32'h0, 32'h0});
    net_master_inst.xfer(1'b1, a, d, rq);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF, input logic err = 1'b0);
    notes.push_back('{1'b1, err, m, e});
    net_master_inst.xfer(1'b0, a, 32'h0, rq);
  endtask
  // Status is cleared first so a restart flag survives for the caller to inspect
  task automatic obj(input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] d,
                     input logic [4:0] c, input logic [31:0] code);
    wr(REG_STATUS, 32'hF);
    wr(REG_REQ_INDEX, {8'h00, sb, ix});
    wr(REG_REQ_DATA, d);
    wr(REG_REQ_CTRL, {27'h0, c});
    repeat (3) @(posedge pclk);
    rd(REG_RESP, code);
    rd(REG_STATUS, {30'h0, code != 32'h0, 1'b1}, 32'h3);
  endtask
  task automatic opchk(input logic [7:0] sb, input logic [31:0] v);
    chk("op_value", v, op_value);
    chk("op_index", 32'h2000, {16'h0, op_index});
    chk("op_subindex", {24'h0, sb}, {24'h0, op_subindex});
  endtask
  task automatic irqchk(input logic [7:0] a, input logic [31:0] d, input logic e);
    wr(a, d);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  initial
  begin
    presetn = 1'b0;
    seed    = 59722;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(REG_STATUS, 32'h0);
    rd(REG_MASK, 32'h0);
    rd(8'h24, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(8'h26, 32'h1, 1'b1);
    foreach (bad_ix[i])
      obj(bad_ix[i], 8'h01, 32'h1, 5'h03, ABORT_NO_OBJ);
    obj(16'h2010, 8'h01, 32'h1, 5'h03, ABORT_NO_OBJ);
    obj(16'h2000, 8'h00, 32'h1, 5'h03, ABORT_NO_OBJ);
    chk("op_value", 32'h0, op_value);
    rv = $random(seed) & 32'hFFFF;
    obj(16'h2000, 8'h01, rv, 5'h03, ABORT_NONE);
    opchk(8'h01, rv);
    obj(16'h2000, 8'h01, 32'h0, 5'h01, ABORT_NONE);
    rd(REG_RESP_DATA, rv);
    rd(REG_ATTR, 32'h0005_2090);
    obj(16'h2000, 8'h01, 32'hFFFF, 5'h03, ABORT_NONE);
    obj(16'h2000, 8'h01, 32'h1_0000, 5'h03, ABORT_RANGE);
    opchk(8'h01, 32'hFFFF);
    obj(16'h2000, 8'h05, 32'h1_2345, 5'h07, ABORT_NONE);
    opchk(8'h05, 32'h1_2345);
    obj(16'h2000, 8'h01, 32'h0, 5'h11, ABORT_NOMAP);
    obj(16'h2000, 8'h05, 32'h0, 5'h19, ABORT_NOMAP);
    obj(16'h2000, 8'h05, 32'h0, 5'h11, ABORT_NONE);
    obj(16'h2000, 8'h09, 32'h0, 5'h19, ABORT_NONE);
    irqchk(REG_MASK, 32'h1, 1'b1);
    irqchk(REG_MASK, 32'h0, 1'b0);
    irqchk(REG_MASK, 32'h1, 1'b1);
    irqchk(REG_STATUS, 32'hF, 1'b0);
    wr(REG_MASK, 32'h0);
    wr(REG_NETSTATE, 32'h1);
    obj(16'h2000, 8'h02, 32'h7, 5'h03, ABORT_STATE);
    obj(16'h2000, 8'h01, 32'h42, 5'h03, ABORT_NONE);
    opchk(8'h01, 32'h42);
    obj(16'h2000, 8'h03, 32'h55, 5'h03, ABORT_NONE);
    opchk(8'h01, 32'h42);
    wr(REG_NETSTATE, 32'h0);
    repeat (3) @(posedge pclk);
    opchk(8'h03, 32'h55);
    rd(REG_STATUS, 32'h8, 32'h8);
    obj(16'h2000, 8'h03, 32'h100, 5'h03, ABORT_RANGE);
    obj(16'h2000, 8'h02, 32'h7, 5'h03, ABORT_NONE);
    opchk(8'h02, 32'h7);
    obj(16'h2000, 8'h0D, 32'h1, 5'h03, ABORT_NONE);
    obj(16'h2000, 8'h0D, 32'h2, 5'h03, ABORT_NONE);
    opchk(8'h02, 32'h7);
    rd(REG_STATUS, 32'h4, 32'h4);
    chk("warning_code", {16'h0, RESTART_REQUIRED_WARNING}, {16'h0, warning_code});
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("op_value", 32'h0, op_value);
    presetn <= 1'b1;
    rd(REG_STATUS, 32'h0);
    stop_test();
  end
endmodule
